// ### src/ssq_step_sequencer.sv
// sixteen-step output sequencer with timer and event transitions
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module ssq_step_sequencer #(
  parameter int TICK_CYCLES = ssq_pkg::TICK_CYC
) (
  input wire logic clk, // 25 MHz
  input wire logic reset, // async, active high
  input wire ssq_pkg::ssq_bus_req_type busReq, // register access
  output logic [ssq_pkg::DW-1:0] rdata, // read data, cycle after rd
  input wire ssq_pkg::ssq_ctl_type ctlPins, // start, reset, jog, run
  input wire logic [ssq_pkg::OUTS-1:0] eventInputPoint, // event pins
  input wire logic scanStrobe, // one pulse per scan
  output logic [ssq_pkg::OUTS-1:0] seqOut, // step pattern outputs
  output logic cycleDone // done bit of first counter
);
  import ssq_pkg::*;

  typedef logic [$clog2(TICK_CYCLES)-1:0] ssq_pre_type;
  localparam ssq_pre_type PRE_LAST = ssq_pre_type'(TICK_CYCLES - 1);

  // synchronisers: first stage read only by second
  ssq_ctl_type ctlMeta_q, ctlSync_q;
  logic [OUTS-1:0] evtMeta_q, evtSync_q;
  logic jogPrev_q, runPrev_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctlMeta_q <= '0;
      ctlSync_q <= '0;
    end else begin
      ctlMeta_q <= ctlPins;
      ctlSync_q <= ctlMeta_q;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      evtMeta_q <= '0;
      evtSync_q <= '0;
    end else begin
      evtMeta_q <= eventInputPoint;
      evtSync_q <= evtMeta_q;
    end
  end

  // edge history taken from the synced copies, never the first stage
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      jogPrev_q <= 1'b0;
      runPrev_q <= 1'b0;
    end else begin
      jogPrev_q <= ctlSync_q.jog;
      runPrev_q <= ctlSync_q.runMode;
    end
  end

  // configuration registers
  logic [DW-1:0] ctrl_q, timebase_q, mask_q, relay_q;
  logic [DW-1:0] pattern_q [STEPS];
  logic [DW-1:0] limit_q [STEPS];
  logic [DW-1:0] stepCfg_q [STEPS];
  logic [DW-1:0] stepCount_q, tickTimer_q, presetStep_q, curStep_q;
  logic [OUTS-1:0] out_q;
  logic done_q;
  logic [DW-1:0] rdata_q;
  ssq_state_type state_q;
  ssq_pre_type pre_q;
  logic tickPend_q;

  logic wrEn;
  logic [3:0] wIdx;
  assign wrEn = busReq.wr;
  assign wIdx = busReq.addr[3:0];

  // values above 9999 saturate
  function automatic logic [DW-1:0] clampSet(input logic [DW-1:0] v);
    clampSet = (v > MAX_SETTING) ? MAX_SETTING : v;
  endfunction

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= CTRL_RESET;
      timebase_q <= TIMEBASE_RESET;
      mask_q <= MASK_RESET;
      relay_q <= '0;
    end else if (wrEn) begin
      unique case (busReq.addr)
        REG_CTRL: ctrl_q <= busReq.wdata;
        REG_TIMEBASE: timebase_q <= clampSet(busReq.wdata);
        REG_MASK: mask_q <= busReq.wdata;
        REG_RELAY: relay_q <= busReq.wdata;
        default: ;
      endcase
    end
  end

  // per-step tables
  generate
    for (genvar s = 0; s < STEPS; s++) begin : g_step
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          pattern_q[s] <= '0;
          limit_q[s] <= '0;
          stepCfg_q[s] <= CFG_RESET;
        end else if (wrEn && wIdx == 4'(s)) begin
          if (busReq.addr[7:4] == PAGE_PATTERN)
            pattern_q[s] <= busReq.wdata;
          if (busReq.addr[7:4] == PAGE_LIMIT)
            limit_q[s] <= clampSet(busReq.wdata);
          if (busReq.addr[7:4] == PAGE_CFG)
            stepCfg_q[s] <= busReq.wdata;
        end
      end
    end
  endgenerate

  // decoded control fields
  ssq_variant_type variant;
  logic retentive;
  logic [3:0] lastIdx, presetCfgIdx, curIdx;
  assign variant = ssq_variant_type'(ctrl_q[CTRL_VAR_LSB +: 2]);
  assign retentive = ctrl_q[CTRL_RET_BIT];
  assign lastIdx = ctrl_q[CTRL_LAST_LSB +: 4];
  assign presetCfgIdx = ctrl_q[CTRL_PRE_LSB +: 4];
  // steps 1..16 held as index 0..15
  assign curIdx = 4'(curStep_q - STEP_FIRST);

  // current step condition
  logic [DW-1:0] cfg;
  logic useTimer, useEvent, evtTrue;
  ssq_evt_src_type evtSrc;
  logic [3:0] evtIdx;
  assign cfg = stepCfg_q[curIdx];
  assign evtSrc = ssq_evt_src_type'(cfg[CFG_TYPE_LSB +: 2]);
  assign evtIdx = cfg[CFG_IDX_LSB +: 4];

  always_comb begin
    unique case (evtSrc)
      EVT_INPUT: evtTrue = evtSync_q[evtIdx];
      EVT_OUTPUT: evtTrue = out_q[evtIdx];
      EVT_RELAY: evtTrue = relay_q[evtIdx];
      EVT_NONE: evtTrue = 1'b0;
    endcase
  end

  always_comb begin
    if (variant == VAR_TIMED) begin
      useTimer = 1'b1;
      useEvent = 1'b0;
    end else begin
      useTimer = cfg[CFG_TIMER_BIT] | ~cfg[CFG_EVENT_BIT];
      useEvent = cfg[CFG_EVENT_BIT];
    end
  end

  // sequencing decisions; advance taken only on a scan, jog edge on any cycle
  logic runOk, timerRun, rollover, advance, jogEdge, runEntry, holdRst;
  logic [DW-1:0] tbEff;
  assign holdRst = ctlSync_q.seqReset;
  assign runOk = ctlSync_q.runMode && !holdRst && ctlSync_q.start
                 && state_q == SQ_RUN;
  assign timerRun = runOk && useTimer && (!useEvent || evtTrue);
  assign tbEff = (timebase_q == '0) ? TIMEBASE_RESET : timebase_q;
  assign rollover = timerRun && tickPend_q
                    && (tickTimer_q + STEP_FIRST >= tbEff);
  assign jogEdge = ctlSync_q.jog && !jogPrev_q && !holdRst
                   && variant == VAR_TIME_EVENT
                   && state_q == SQ_RUN;
  assign runEntry = ctlSync_q.runMode && !runPrev_q;
  always_comb begin
    advance = 1'b0;
    if (scanStrobe && runOk) begin
      if (useTimer)
        advance = stepCount_q >= limit_q[curIdx]
                  && (!useEvent || evtTrue);
      else
        advance = evtTrue;
    end
  end

  logic atLast;
  assign atLast = curIdx >= lastIdx;

  // 0.01 s prescaler; pending tick kept until the next scan, used or not
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pre_q <= '0;
    end else begin
      pre_q <= (pre_q == PRE_LAST) ? '0 : pre_q + 1'b1;
    end
  end

  // a scan faster than the tick never loses one: set wins over clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tickPend_q <= 1'b0;
    end else if (pre_q == PRE_LAST) begin
      tickPend_q <= 1'b1;
    end else if (scanStrobe) begin
      tickPend_q <= 1'b0;
    end
  end

  // shared qualifiers for the state and counter word blocks
  logic reload, cntWr, stepMove, lastMove;
  logic [DW-1:0] presetLoad;
  assign reload = runEntry && !retentive;
  assign cntWr = wrEn && busReq.addr[7:2] == REG_STEP_COUNT[7:2];
  assign stepMove = advance || jogEdge;
  assign lastMove = stepMove && atLast && !cntWr;
  assign presetLoad = DW'(presetCfgIdx) + STEP_FIRST;

  // sequencer state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= SQ_HOLD;
    end else if (reload) begin
      state_q <= SQ_RUN;
    end else if (holdRst) begin
      state_q <= SQ_HOLD;
    end else if (lastMove) begin
      state_q <= SQ_DONE;
    end else if (!cntWr && state_q == SQ_HOLD) begin
      state_q <= SQ_RUN;
    end
  end

  // completion flag; a held sequencer reset wins over completion
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      done_q <= 1'b0;
    end else if (reload || holdRst) begin
      done_q <= 1'b0;
    end else if (lastMove) begin
      done_q <= 1'b1;
    end
  end

  // counts in step
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stepCount_q <= '0;
    end else if (reload || holdRst) begin
      stepCount_q <= '0;
    end else if (cntWr) begin
      if (busReq.addr[1:0] == REG_STEP_COUNT[1:0])
        stepCount_q <= busReq.wdata;
    end else if (stepMove) begin
      stepCount_q <= '0;
    end else if (scanStrobe && rollover && stepCount_q < MAX_SETTING) begin
      stepCount_q <= stepCount_q + STEP_FIRST;
    end
  end

  // sub-count timer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tickTimer_q <= '0;
    end else if (reload || holdRst) begin
      tickTimer_q <= '0;
    end else if (cntWr) begin
      if (busReq.addr[1:0] == REG_TICK_TIMER[1:0])
        tickTimer_q <= busReq.wdata;
    end else if (stepMove || (scanStrobe && rollover)) begin
      tickTimer_q <= '0;
    end else if (scanStrobe && timerRun && tickPend_q) begin
      tickTimer_q <= tickTimer_q + STEP_FIRST;
    end
  end

  // preset step word, written only by software or a fresh run entry
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      presetStep_q <= STEP_FIRST;
    end else if (reload) begin
      presetStep_q <= presetLoad;
    end else if (!holdRst && cntWr
                 && busReq.addr[1:0] == REG_PRESET[1:0]) begin
      presetStep_q <= busReq.wdata;
    end
  end

  // current step number
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      curStep_q <= STEP_FIRST;
    end else if (reload) begin
      curStep_q <= presetLoad;
    end else if (holdRst) begin
      curStep_q <= presetStep_q;
    end else if (cntWr) begin
      if (busReq.addr[1:0] == REG_CURRENT[1:0])
        curStep_q <= busReq.wdata;
    end else if (stepMove && !atLast) begin
      curStep_q <= curStep_q + STEP_FIRST;
    end
  end

  // outputs follow the current step while in run mode
  logic [OUTS-1:0] pat;
  assign pat = pattern_q[curIdx];
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_q <= '0;
    end else if (!ctlSync_q.runMode) begin
      out_q <= '0;
    end else begin
      unique case (variant)
        VAR_TIMED, VAR_TIME_EVENT: out_q <= pat & mask_q;
        // discrete coils under a cleared mask bit are left alone
        VAR_MASKED_BIT: out_q <= (pat & mask_q) | (out_q & ~mask_q);
        VAR_MASKED_WORD: out_q <= pat & mask_q;
      endcase
    end
  end

  // read path, data one cycle after the strobe
  logic [DW-1:0] rdMux;
  always_comb begin
    rdMux = '0;
    unique case (busReq.addr[7:4])
      4'h0: begin
        unique case (busReq.addr[3:0])
          REG_CTRL[3:0]: rdMux = ctrl_q;
          REG_TIMEBASE[3:0]: rdMux = timebase_q;
          REG_MASK[3:0]: rdMux = mask_q;
          REG_RELAY[3:0]: rdMux = relay_q;
          REG_STEP_COUNT[3:0]: rdMux = stepCount_q;
          REG_TICK_TIMER[3:0]: rdMux = tickTimer_q;
          REG_PRESET[3:0]: rdMux = presetStep_q;
          REG_CURRENT[3:0]: rdMux = curStep_q;
          REG_STATUS[3:0]: begin
            rdMux[ST_DONE_BIT] = done_q;
            rdMux[ST_RUN_BIT] = state_q == SQ_RUN;
            rdMux[ST_HOLD_BIT] = state_q == SQ_HOLD;
          end
          default: rdMux = '0;
        endcase
      end
      PAGE_PATTERN: rdMux = pattern_q[wIdx];
      PAGE_LIMIT: rdMux = limit_q[wIdx];
      PAGE_CFG: rdMux = stepCfg_q[wIdx];
      default: rdMux = '0;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      rdata_q <= '0;
    else
      rdata_q <= busReq.rd ? rdMux : '0;
  end

  assign rdata = rdata_q;
  assign seqOut = out_q;
  assign cycleDone = done_q;
endmodule

// ### src/ssq_pkg.sv
// step sequencer constants, types and register map
// Notes on behaviour
// - sixteen steps, each a sixteen-bit output pattern
// - output bits 0..15, steps numbered 1..16
// - one shared timebase, 0.01 s to 99.99 s
// - dwell equals 0.01 s times timebase times limit
// - timebase and step limits accept up to 9999
// - combined step: timer runs only while event true
// - limit reached: next step, outputs update at once
// - per step timer, event or combined condition
// - fewer steps and fewer outputs may be used
// - event point: input, output or relay type
// - four variants; timed-only has no events
// - word or bit outputs; masked variants gate bits
// - four counter words: count, timer, preset, step
// - timer word counts 0.01 s toward timebase
// - done bit sets on completion, clears on reset
// - reset loads preset step into current step
// - preset word changes by write or restart only
// - evaluated once per scan; timebase near scan
// - reset beats start; start off stops timer and event steps, jog still advances
// - jog edge advances, clears timer, combined variant
// - last step done: complete, hold, ignore start/jog
// - non-retentive run entry clears counters, loads preset
package ssq_pkg;
  localparam int STEPS = 16;
  localparam int OUTS = 16;
  localparam int DW = 16;
  localparam int AW = 8;
  localparam int TICK_NS = 10000000;
  localparam int CLK_NS = 40;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam logic [DW-1:0] MAX_SETTING = 16'h270F;
  localparam logic [DW-1:0] STEP_FIRST = 16'h0001;
  localparam logic [DW-1:0] STEP_LAST = 16'h0010;
  // register indices
  localparam logic [AW-1:0] REG_CTRL = 8'h00;
  localparam logic [AW-1:0] REG_TIMEBASE = 8'h01;
  localparam logic [AW-1:0] REG_MASK = 8'h02;
  localparam logic [AW-1:0] REG_RELAY = 8'h03;
  localparam logic [AW-1:0] REG_STEP_COUNT = 8'h04;
  localparam logic [AW-1:0] REG_TICK_TIMER = 8'h05;
  localparam logic [AW-1:0] REG_PRESET = 8'h06;
  localparam logic [AW-1:0] REG_CURRENT = 8'h07;
  localparam logic [AW-1:0] REG_STATUS = 8'h08;
  localparam logic [3:0] PAGE_PATTERN = 4'h1;
  localparam logic [3:0] PAGE_LIMIT = 4'h2;
  localparam logic [3:0] PAGE_CFG = 4'h3;
  // control word fields
  localparam int CTRL_VAR_LSB = 0;
  localparam int CTRL_RET_BIT = 2;
  localparam int CTRL_LAST_LSB = 4;
  localparam int CTRL_PRE_LSB = 8;
  localparam logic [DW-1:0] CTRL_RESET = 16'h0FF0;
  // step config fields
  localparam int CFG_TIMER_BIT = 0;
  localparam int CFG_EVENT_BIT = 1;
  localparam int CFG_TYPE_LSB = 2;
  localparam int CFG_IDX_LSB = 4;
  localparam logic [DW-1:0] CFG_RESET = 16'h0001;
  localparam logic [DW-1:0] TIMEBASE_RESET = 16'h0001;
  localparam logic [DW-1:0] MASK_RESET = 16'hFFFF;
  localparam int ST_DONE_BIT = 0;
  localparam int ST_RUN_BIT = 1;
  localparam int ST_HOLD_BIT = 2;

  typedef enum logic [1:0] {
    VAR_TIMED,
    VAR_TIME_EVENT,
    VAR_MASKED_BIT,
    VAR_MASKED_WORD
  } ssq_variant_type;

  typedef enum logic [1:0] {
    EVT_INPUT,
    EVT_OUTPUT,
    EVT_RELAY,
    EVT_NONE
  } ssq_evt_src_type;

  typedef enum {SQ_HOLD, SQ_RUN, SQ_DONE} ssq_state_type;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
  } ssq_bus_req_type;

  typedef struct packed {
    logic start;
    logic seqReset;
    logic jog;
    logic runMode;
  } ssq_ctl_type;
endpackage

// ### verif/ssq_scan_model.sv
// controller scan pacing model for the step sequencer
`timescale 1ns/10ps
module ssq_scan_model #(
  parameter int SCAN_CYCLES = 2
) (
  input wire logic clk, // clock
  input wire logic reset, // async reset
  output logic scanStrobe // one pulse per scan
);
  int cnt;
  // scan shorter than a tick so no tick is lost
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt <= 0;
      scanStrobe <= 1'b0;
    end else begin
      cnt <= (cnt == SCAN_CYCLES - 1) ? 0 : cnt + 1;
      scanStrobe <= (cnt == SCAN_CYCLES - 1);
    end
  end
endmodule

// ### verif/ssq_step_sequencer_monitor.sv
// port-level assertions for the step sequencer
`timescale 1ns/10ps
module ssq_step_sequencer_monitor (
  input wire logic clk, // clock
  input wire logic reset, // async reset
  input wire ssq_pkg::ssq_bus_req_type busReq, // bus request
  input wire logic [ssq_pkg::DW-1:0] rdata, // read data
  input wire ssq_pkg::ssq_ctl_type ctlPins, // control pins
  input wire logic scanStrobe, // scan pulse
  input wire logic [ssq_pkg::OUTS-1:0] seqOut, // outputs
  input wire logic cycleDone // done bit
);
  import ssq_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  logic rdLimit;
  assign rdLimit = busReq.rd && busReq.addr[7:4] == PAGE_LIMIT;
  idle_rdata_a: assert property (!$past(busReq.rd) |-> rdata == '0)
    else $error("rdata not idle");
  unmapped_read_a: assert property (
    busReq.rd && busReq.addr >= 8'h40 |=> rdata == '0)
    else $error("unmapped read not zero");
  timebase_clamp_a: assert property (
    busReq.rd && busReq.addr == REG_TIMEBASE |=> rdata <= MAX_SETTING)
    else $error("timebase above limit");
  limit_clamp_a: assert property (rdLimit |=> rdata <= MAX_SETTING)
    else $error("step limit above limit");
  step_range_a: assert property (
    busReq.rd && busReq.addr == REG_CURRENT
    |=> rdata inside {[STEP_FIRST:STEP_LAST]})
    else $error("step number out of range");
  status_done_a: assert property (
    busReq.rd && busReq.addr == REG_STATUS
    |=> rdata[ST_DONE_BIT] == $past(cycleDone))
    else $error("status done differs");
  run_off_a: assert property ((!ctlPins.runMode)[*4] |-> seqOut == '0)
    else $error("outputs on outside run");
  reset_clears_a: assert property (ctlPins.seqReset[*4] |-> !cycleDone)
    else $error("done kept under reset");
  done_on_scan_a: assert property ($rose(cycleDone) |-> $past(scanStrobe))
    else $error("done set off scan");
  done_holds_a: assert property (
    (!ctlPins.seqReset && ctlPins.runMode)[*8] ##0 cycleDone |=> cycleDone)
    else $error("done dropped");
  done_c: cover property ($rose(cycleDone));
  step_c: cover property (!$stable(seqOut) && ctlPins.runMode);
  jog_c: cover property ($rose(ctlPins.jog));
endmodule
bind ssq_step_sequencer ssq_step_sequencer_monitor i_mon (.clk(clk),
  .reset(reset), .busReq(busReq), .rdata(rdata), .ctlPins(ctlPins),
  .scanStrobe(scanStrobe), .seqOut(seqOut), .cycleDone(cycleDone));

// ### verif/ssq_step_sequencer_tb_top.sv
// self-checking bench for the step sequencer
`timescale 1ns/10ps
`define CHK(a, e) begin nChecks++; if ((a) !== (e)) begin nFail++; \
  $display("unexpected at %0t: %h vs %h", $time, a, e); end end
module ssq_step_sequencer_tb_top;
  import ssq_pkg::*;
  logic clk, reset, scanStrobe, cycleDone;
  ssq_bus_req_type busReq;
  ssq_ctl_type ctlPins;
  logic [DW-1:0] rdata;
  logic [OUTS-1:0] eventInputPoint, seqOut;
  int nFail = 0;
  int nChecks = 0;
  int i;
  logic [7:0] ra [11] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h00, 8'h01,
    8'h02, 8'h08, 8'h31, 8'h09, 8'h40};
  logic [15:0] rv [11] = '{16'h0000, 16'h0000, 16'h0001, 16'h0001,
    16'h0FF0, 16'h0001, 16'hFFFF, 16'h0002, 16'h0001, 16'h0000, 16'h0000};
  ssq_scan_model i_scan (.clk(clk), .reset(reset), .scanStrobe(scanStrobe));
  // short tick keeps timed steps to a few dozen cycles
  ssq_step_sequencer #(.TICK_CYCLES(4)) i_dut (.clk(clk), .reset(reset),
    .busReq(busReq), .rdata(rdata), .ctlPins(ctlPins),
    .eventInputPoint(eventInputPoint), .scanStrobe(scanStrobe),
    .seqOut(seqOut), .cycleDone(cycleDone));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [15:0] pat(int s);
    return 16'(s * 16'h1357);
  endfunction
  task automatic giveVerdict();
    if (nFail == 0 && nChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    busReq.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    busReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    busReq.rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic chkRd(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    `CHK(d, e)
  endtask
  task automatic waitStep(input logic [15:0] e, input int lim);
    logic [15:0] d;
    int k;
    for (k = 0; k < lim; k++) begin
      rd(REG_CURRENT, d);
      if (d === e) break;
    end
    `CHK(d, e)
    if (k == lim) giveVerdict();
  endtask
  task automatic jogPulse();
    @(posedge clk) ctlPins.jog <= 1'b1;
    cyc(4);
    @(posedge clk) ctlPins.jog <= 1'b0;
  endtask
  initial begin
    busReq = '0;
    ctlPins = '0;
    eventInputPoint = '0;
    reset = 1'b1;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    cyc(2);
    for (i = 0; i < 11; i++) chkRd(ra[i], rv[i]);
    wr(8'h45, 16'hBEEF);
    chkRd(8'h45, 16'h0000);
    for (i = 1; i <= 16; i++) wr({PAGE_PATTERN, 4'(i - 1)}, pat(i));
    wr(REG_TIMEBASE, 16'hFFFF);
    chkRd(REG_TIMEBASE, MAX_SETTING);
    wr({PAGE_LIMIT, 4'h3}, 16'hFFFF);
    chkRd({PAGE_LIMIT, 4'h3}, MAX_SETTING);
    wr(REG_TIMEBASE, 16'h0002);
    wr({PAGE_LIMIT, 4'h0}, 16'h0003);
    wr({PAGE_LIMIT, 4'h2}, 16'h0001);
    wr({PAGE_CFG, 4'h1}, 16'h0032);
    wr({PAGE_CFG, 4'h2}, 16'h0053);
    for (i = 0; i < 4; i++) begin
      wr(REG_CTRL, 16'(16'h0020 | i));
      chkRd(REG_CTRL, 16'(16'h0020 | i));
    end
    wr(REG_CTRL, 16'h0021);
    @(posedge clk) ctlPins.runMode <= 1'b1;
    cyc(40);
    chkRd(REG_PRESET, 16'h0001);
    chkRd(REG_CURRENT, 16'h0001);
    `CHK(seqOut, pat(1))
    @(posedge clk) ctlPins.start <= 1'b1;
    cyc(16);
    chkRd(REG_CURRENT, 16'h0001);
    waitStep(16'h0002, 12);
    chkRd(REG_STEP_COUNT, 16'h0000);
    cyc(40);
    chkRd(REG_CURRENT, 16'h0002);
    @(posedge clk) eventInputPoint[3] <= 1'b1;
    waitStep(16'h0003, 10);
    cyc(60);
    chkRd(REG_CURRENT, 16'h0003);
    `CHK(seqOut, pat(3))
    @(posedge clk) eventInputPoint[5] <= 1'b1;
    for (i = 0; i < 100 && cycleDone !== 1'b1; i++) cyc(1);
    `CHK(cycleDone, 1'b1)
    if (i == 100) giveVerdict();
    jogPulse();
    cyc(10);
    chkRd(REG_CURRENT, 16'h0003);
    `CHK(seqOut, pat(3))
    @(posedge clk) ctlPins.start <= 1'b0;
    eventInputPoint <= '0;
    wr(REG_PRESET, 16'h0002);
    chkRd(REG_PRESET, 16'h0002);
    @(posedge clk) ctlPins.seqReset <= 1'b1;
    cyc(12);
    chkRd(REG_CURRENT, 16'h0002);
    chkRd(REG_PRESET, 16'h0002);
    `CHK(cycleDone, 1'b0)
    @(posedge clk) ctlPins.seqReset <= 1'b0;
    cyc(12);
    `CHK(seqOut, pat(2))
    jogPulse();
    waitStep(16'h0003, 10);
    chkRd(REG_TICK_TIMER, 16'h0000);
    wr(REG_CTRL, 16'h0022);
    wr(REG_MASK, 16'h00FF);
    cyc(8);
    `CHK(seqOut, pat(3))
    wr(REG_CTRL, 16'h0023);
    cyc(8);
    `CHK(seqOut, pat(3) & 16'h00FF)
    @(posedge clk) ctlPins.runMode <= 1'b0;
    cyc(8);
    `CHK(seqOut, 16'h0000)
    giveVerdict();
  end
endmodule
